// File: dswt_pkg.sv
// dswt_pkg: constants and types for the drive status word telegram block.
// assumes every file of the block refers to names here as dswt_pkg::name.
package dswt_pkg;

   // widths of words, connector numbers and process-data positions
   localparam int unsigned WORD_W       = 16;
   localparam int unsigned CONN_W       = 10;
   localparam int unsigned LEN_W        = 5;
   localparam int unsigned IDX_W        = 4;
   localparam int unsigned MAX_PD_WORDS = 16;
   localparam int unsigned RAW_W        = 18;
   localparam int unsigned PNUM_W       = 11;
   localparam int unsigned CODE_W       = 4;

   // connector numbers of the three status words
   localparam logic [CONN_W-1:0] CONN_STATUS_ONE   = 10'h145; // 325
   localparam logic [CONN_W-1:0] CONN_STATUS_TWO   = 10'h146; // 326
   localparam logic [CONN_W-1:0] CONN_STATUS_THREE = 10'h147; // 327

   // bit positions of status word one
   localparam int unsigned BIT_READY       = 0;
   localparam int unsigned BIT_DISABLED    = 1;
   localparam int unsigned BIT_RUNNING     = 2;
   localparam int unsigned BIT_FAULT       = 3;
   localparam int unsigned BIT_COAST       = 4;
   localparam int unsigned BIT_QUICK       = 5;
   localparam int unsigned BIT_BLOCKED     = 6;
   localparam int unsigned BIT_WARNING     = 7;
   localparam int unsigned BIT_SPEED_TOL   = 8;
   localparam int unsigned BIT_SPEED_ABOVE = 10;

   // actual-value scaling: nominal full scale and 16-bit saturation
   localparam logic signed [WORD_W-1:0] NOMINAL_POS = 16'sh4000; // +16384
   localparam logic signed [WORD_W-1:0] NOMINAL_NEG = 16'shC000; // -16384
   localparam logic signed [RAW_W-1:0]  SAT_MAX     = 18'sh07FFF;
   localparam logic signed [RAW_W-1:0]  SAT_MIN     = 18'sh38000;

   // parameter numbers served on the parameter channel
   localparam logic [PNUM_W-1:0] PNUM_PD_LEN_A  = 11'h30D; // 781
   localparam logic [PNUM_W-1:0] PNUM_SEL_A     = 11'h310; // 784
   localparam logic [PNUM_W-1:0] PNUM_PD_LEN_B  = 11'h317; // 791
   localparam logic [PNUM_W-1:0] PNUM_SEL_B     = 11'h31A; // 794
   localparam logic [PNUM_W-1:0] PNUM_FAULT     = 11'h390; // 912
   localparam logic [PNUM_W-1:0] PNUM_WARN      = 11'h391; // 913
   localparam logic [PNUM_W-1:0] PNUM_SPEED_TOL = 11'h398; // 920

   // parameter-channel word 1 layout
   localparam int unsigned PKW_CODE_LO = 12;
   localparam int unsigned PKW_NUM_HI  = 10;

   // request and response codes
   localparam logic [CODE_W-1:0] REQ_READ_IDX   = 4'h6;
   localparam logic [CODE_W-1:0] REQ_WRITE_IDX  = 4'h7;
   localparam logic [CODE_W-1:0] RESP_IDX_VALUE = 4'h4;
   localparam logic [CODE_W-1:0] RESP_ERROR     = 4'h7;

   // coded error numbers
   localparam logic [WORD_W-1:0] ERR_UNDEF_PARAM = 16'h0000;
   localparam logic [WORD_W-1:0] ERR_READ_ONLY   = 16'h0001;
   localparam logic [WORD_W-1:0] ERR_LIMIT       = 16'h0002;
   localparam logic [WORD_W-1:0] ERR_UNDEF_INDEX = 16'h0003;
   localparam logic [WORD_W-1:0] ERR_NO_FUNC     = 16'h0065; // 101

   // reset values of the settings, and the process-data length limit
   localparam logic [LEN_W-1:0]  RST_PD_LEN    = 5'h00;
   localparam logic [LEN_W-1:0]  MAX_PD_LEN    = 5'h10;
   localparam logic [CONN_W-1:0] RST_SEL_FIRST = 10'h145;
   localparam logic [CONN_W-1:0] RST_SEL_OTHER = 10'h000;
   localparam logic [WORD_W-1:0] RST_SPEED_TOL = 16'h0200;

   // transmit sequencer states
   typedef enum logic [0:0] {TX_IDLE, TX_SEND} dswt_tx_t;

endpackage : dswt_pkg

// File: dswt_link_if.sv
// dswt_link_if: carries status word one and the word-selection query
// between the core and its two helper modules; all on one clock.
`timescale 1ns/1ps
`default_nettype none
interface dswt_link_if;
   logic [15:0] status_word_one; // assembled status word one
   logic [9:0]  sel_connector;   // connector being looked up
   logic [15:0] sel_word;        // word that connector yields

   modport status_src (output status_word_one);
   modport select_eng (input status_word_one, input sel_connector,
                       output sel_word);
   modport core       (input status_word_one, input sel_word,
                       output sel_connector);
endinterface : dswt_link_if
`default_nettype wire

// File: dswt_status_word.sv
// dswt_status_word: builds status word one from the drive's state flags.
// assumes all inputs come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module dswt_status_word (
   input  wire logic        clock,          // system clock
   input  wire logic        arst_n,         // async reset, active low
   input  wire logic        base_ready,     // base unit ready to start
   input  wire logic        start_request,  // a start is requested
   input  wire logic        drive_disabled, // drive is disabled
   input  wire logic        running,        // base unit running
   input  wire logic        fault_active,   // any fault present
   input  wire logic        warning_active, // any warning present
   input  wire logic        coast_stop_n,   // 0 while coast stop active
   input  wire logic        quick_stop_n,   // 0 while quick stop active
   input  wire logic        other_block,    // other missing permissive
   input  wire logic        speed_above,    // speed above threshold
   input  wire logic [15:0] speed_ref,      // active speed reference
   input  wire logic [15:0] speed_fb,       // actual speed feedback
   input  wire logic [15:0] speed_tol,      // tolerance band half-width
   dswt_link_if.status_src  link            // status word to the core
);

   typedef struct packed {
      logic [15:0] word;
   } dswt_sw_state_t;

   dswt_sw_state_t cur;
   dswt_sw_state_t next_cur;

   // error magnitude of reference minus feedback, both signed
   function automatic logic [16:0] dswt_abs_err(input logic [15:0] a,
                                                 input logic [15:0] b);
      logic signed [16:0] d;
      d = $signed({a[15], a}) - $signed({b[15], b});
      dswt_abs_err = d[16] ? 17'(-d) : 17'(d);
   endfunction : dswt_abs_err

   // assemble every flag of the word; unused bits stay zero
   always_comb begin
      next_cur = '0;
      next_cur.word[dswt_pkg::BIT_READY]    = base_ready & ~start_request;
      next_cur.word[dswt_pkg::BIT_DISABLED] = drive_disabled & start_request;
      next_cur.word[dswt_pkg::BIT_RUNNING]  = running;
      next_cur.word[dswt_pkg::BIT_FAULT]    = fault_active;
      next_cur.word[dswt_pkg::BIT_COAST]    = coast_stop_n;
      next_cur.word[dswt_pkg::BIT_QUICK]    = quick_stop_n;
      next_cur.word[dswt_pkg::BIT_BLOCKED]  = other_block |
         (~start_request & (~coast_stop_n | ~quick_stop_n));
      next_cur.word[dswt_pkg::BIT_WARNING]  = warning_active;
      next_cur.word[dswt_pkg::BIT_SPEED_TOL] =
         dswt_abs_err(speed_ref, speed_fb) <= {1'b0, speed_tol};
      next_cur.word[dswt_pkg::BIT_SPEED_ABOVE] = speed_above;
   end

   // register the word
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign link.status_word_one = cur.word;

endmodule : dswt_status_word
`default_nettype wire

// File: dswt_word_select.sv
// dswt_word_select: maps a connector number to the word it carries.
// assumes conn_raw answers conn_query in the same cycle, combinationally.
`timescale 1ns/1ps
`default_nettype none
module dswt_word_select (
   input  wire logic [15:0] status_word_two,   // status word two value
   input  wire logic [15:0] status_word_three, // status word three value
   output logic      [9:0]  conn_query,        // connector asked for
   input  wire logic [17:0] conn_raw,          // its raw signed value
   dswt_link_if.select_eng  link               // query and answer
);

   // clamp a raw value, nominal full scale 16384, to a signed word
   function automatic logic [15:0] dswt_sat(input logic [17:0] raw);
      if ($signed(raw) > dswt_pkg::SAT_MAX) begin
         dswt_sat = dswt_pkg::SAT_MAX[15:0];
      end else if ($signed(raw) < dswt_pkg::SAT_MIN) begin
         dswt_sat = dswt_pkg::SAT_MIN[15:0];
      end else begin
         dswt_sat = raw[15:0];
      end
   endfunction : dswt_sat

   assign conn_query = link.sel_connector;

   // status words by their connectors, all else as a scaled value
   always_comb begin
      case (link.sel_connector)
         dswt_pkg::CONN_STATUS_ONE: begin
            link.sel_word = link.status_word_one;
         end
         dswt_pkg::CONN_STATUS_TWO: begin
            link.sel_word = status_word_two;
         end
         dswt_pkg::CONN_STATUS_THREE: begin
            link.sel_word = status_word_three;
         end
         default: begin
            link.sel_word = dswt_sat(conn_raw);
         end
      endcase
   end

endmodule : dswt_word_select
`default_nettype wire

// File: dswt_top.sv
// dswt_top: drive status word telegram block. holds the process-data
// settings of two serial ports, answers parameter-channel requests and
// sends the drive-to-host process-data words of a telegram.
// assumes one clock, requests and flags from logic on that clock.
//
// Overview of operation
// - word 1 is status word one only if length > 0 and it selects 325.
// - bit 0 is 1 when ready to start and falls once start is requested.
// - bit 1 is 1 when the drive is disabled with a start request.
// - bit 3 is 1 while any fault is active.
// - bit 4 follows coast stop, 0 while coast stop is active.
// - bit 5 follows quick stop, 0 while quick stop is active.
// - bit 6 is 1 when blocked, and with no start if a stop is active.
// - bit 7 is 1 while any warning is active.
// - bit 8 is 1 while reference minus feedback is within tolerance.
// - actual values are signed with full scale at +16384 and -16384.
// - words beyond the configured length are not sent.
// - status words two and three go only where their connectors sit.
// - each word carries the value of the connector selected for it.
`timescale 1ns/1ps
`default_nettype none
module dswt_top (
   input  wire logic        clock,             // 200 MHz system clock
   input  wire logic        arst_n,            // async reset, active low
   input  wire logic        base_ready,        // base unit ready to start
   input  wire logic        start_request,     // a start is requested
   input  wire logic        drive_disabled,    // drive is disabled
   input  wire logic        running,           // base unit running
   input  wire logic        fault_active,      // any fault present
   input  wire logic        warning_active,    // any warning present
   input  wire logic        coast_stop_n,      // 0 while coast stop active
   input  wire logic        quick_stop_n,      // 0 while quick stop active
   input  wire logic        other_block,       // other missing permissive
   input  wire logic        speed_above,       // speed above threshold
   input  wire logic [15:0] speed_ref,         // active speed reference
   input  wire logic [15:0] speed_fb,          // actual speed feedback
   input  wire logic [15:0] fault_number,      // active fault number
   input  wire logic [15:0] warning_number,    // active warning number
   input  wire logic [15:0] status_word_two,   // status word two value
   input  wire logic [15:0] status_word_three, // status word three value
   output logic      [9:0]  conn_query,        // connector looked up
   input  wire logic [17:0] conn_raw,          // raw value of conn_query
   input  wire logic        pkw_req_valid,     // request pulse
   input  wire logic [15:0] pkw_req_w1,        // code and param number
   input  wire logic [15:0] pkw_req_w2,        // index
   input  wire logic [15:0] pkw_req_w3,        // value to write
   output logic             pkw_resp_valid,    // response pulse
   output logic      [15:0] pkw_resp_w1,       // code and param number
   output logic      [15:0] pkw_resp_w2,       // index
   output logic      [15:0] pkw_resp_w3,       // value or error number
   input  wire logic        tx_start,          // start a telegram
   input  wire logic        tx_port,           // 0 port a, 1 port b
   output logic             tx_busy,           // telegram under way
   output logic             pd_valid,          // word on pd_word
   input  wire logic        pd_ready,          // sink takes the word
   output logic      [15:0] pd_word,           // process-data word
   output logic      [3:0]  pd_index,          // its position, 0 first
   output logic             pd_last            // last word of telegram
);

   typedef dswt_pkg::dswt_tx_t dswt_tx_t;

   typedef struct packed {
      logic [4:0]        pd_len_a;  // process_data_length_port_a
      logic [4:0]        pd_len_b;  // process_data_length_port_b
      logic [15:0][9:0]  sel_a;     // word_source_select_port_a
      logic [15:0][9:0]  sel_b;     // word_source_select_port_b
      logic [15:0]       speed_tol; // speed tolerance band
      dswt_tx_t          tx;
      logic              tx_port;
      logic [3:0]        tx_idx;
      logic [15:0]       pd_word;
      logic              resp_valid;
      logic [15:0]       resp_w1;
      logic [15:0]       resp_w2;
      logic [15:0]       resp_w3;
   } dswt_core_t;

   dswt_core_t  cur;
   dswt_core_t  next_cur;
   dswt_link_if link ();

   logic        load_port;
   logic [3:0]  load_idx;
   logic [4:0]  cur_len;

   // length of the port a telegram runs on, or would start on
   function automatic logic [4:0] dswt_len(input logic port,
                                           input logic [4:0] len_a,
                                           input logic [4:0] len_b);
      dswt_len = port ? len_b : len_a;
   endfunction : dswt_len

   dswt_status_word u_status (
      .clock          (clock),
      .arst_n         (arst_n),
      .base_ready     (base_ready),
      .start_request  (start_request),
      .drive_disabled (drive_disabled),
      .running        (running),
      .fault_active   (fault_active),
      .warning_active (warning_active),
      .coast_stop_n   (coast_stop_n),
      .quick_stop_n   (quick_stop_n),
      .other_block    (other_block),
      .speed_above    (speed_above),
      .speed_ref      (speed_ref),
      .speed_fb       (speed_fb),
      .speed_tol      (cur.speed_tol),
      .link           (link.status_src)
   );

   dswt_word_select u_select (
      .status_word_two   (status_word_two),
      .status_word_three (status_word_three),
      .conn_query        (conn_query),
      .conn_raw          (conn_raw),
      .link              (link.select_eng)
   );

   // word to fetch next: first word at start, following word while sending
   assign load_port = (cur.tx == dswt_pkg::TX_IDLE) ? tx_port : cur.tx_port;
   assign load_idx  = (cur.tx == dswt_pkg::TX_IDLE) ? 4'h0
                                                    : 4'(cur.tx_idx + 4'h1);
   assign cur_len   = dswt_len(cur.tx_port, cur.pd_len_a, cur.pd_len_b);
   assign link.sel_connector = load_port ? cur.sel_b[load_idx]
                                         : cur.sel_a[load_idx];

   // parameter channel and telegram sequencer
   always_comb begin
      logic [3:0]  code;
      logic [10:0] num;
      logic [15:0] idx;
      logic [15:0] val;
      logic        wr;
      logic [3:0]  rcode;
      logic [15:0] rval;
      code  = pkw_req_w1[15:dswt_pkg::PKW_CODE_LO];
      num   = pkw_req_w1[dswt_pkg::PKW_NUM_HI:0];
      idx   = pkw_req_w2;
      val   = pkw_req_w3;
      wr    = (code == dswt_pkg::REQ_WRITE_IDX);
      rcode = dswt_pkg::RESP_ERROR;
      rval  = dswt_pkg::ERR_NO_FUNC;
      next_cur = cur;
      next_cur.resp_valid = 1'b0;

      // parameter-channel request: read or write one indexed parameter
      if (pkw_req_valid) begin
         if (code == dswt_pkg::REQ_READ_IDX || wr) begin
            rval = dswt_pkg::ERR_UNDEF_PARAM;
            case (num)
               dswt_pkg::PNUM_PD_LEN_A, dswt_pkg::PNUM_PD_LEN_B: begin
                  if (idx != 16'h0000) begin
                     rval = dswt_pkg::ERR_UNDEF_INDEX;
                  end else if (wr && val > 16'(dswt_pkg::MAX_PD_LEN)) begin
                     rval = dswt_pkg::ERR_LIMIT;
                  end else begin
                     rcode = dswt_pkg::RESP_IDX_VALUE;
                     if (wr && num == dswt_pkg::PNUM_PD_LEN_A) begin
                        next_cur.pd_len_a = val[4:0];
                     end else if (wr) begin
                        next_cur.pd_len_b = val[4:0];
                     end
                     rval = wr ? val : 16'(dswt_len(
                        num == dswt_pkg::PNUM_PD_LEN_B,
                        cur.pd_len_a, cur.pd_len_b));
                  end
               end
               dswt_pkg::PNUM_SEL_A, dswt_pkg::PNUM_SEL_B: begin
                  if (idx >= 16'(dswt_pkg::MAX_PD_WORDS)) begin
                     rval = dswt_pkg::ERR_UNDEF_INDEX;
                  end else if (wr && val > 16'h03FF) begin
                     rval = dswt_pkg::ERR_LIMIT;
                  end else begin
                     rcode = dswt_pkg::RESP_IDX_VALUE;
                     if (num == dswt_pkg::PNUM_SEL_A) begin
                        rval = {6'h00, cur.sel_a[idx[3:0]]};
                        if (wr) begin
                           next_cur.sel_a[idx[3:0]] = val[9:0];
                        end
                     end else begin
                        rval = {6'h00, cur.sel_b[idx[3:0]]};
                        if (wr) begin
                           next_cur.sel_b[idx[3:0]] = val[9:0];
                        end
                     end
                     if (wr) begin
                        rval = val;
                     end
                  end
               end
               dswt_pkg::PNUM_FAULT, dswt_pkg::PNUM_WARN: begin
                  if (idx != 16'h0000) begin
                     rval = dswt_pkg::ERR_UNDEF_INDEX;
                  end else if (wr) begin
                     rval = dswt_pkg::ERR_READ_ONLY;
                  end else begin
                     rcode = dswt_pkg::RESP_IDX_VALUE;
                     rval  = (num == dswt_pkg::PNUM_FAULT) ? fault_number
                                                           : warning_number;
                  end
               end
               dswt_pkg::PNUM_SPEED_TOL: begin
                  if (idx != 16'h0000) begin
                     rval = dswt_pkg::ERR_UNDEF_INDEX;
                  end else begin
                     rcode = dswt_pkg::RESP_IDX_VALUE;
                     rval  = wr ? val : cur.speed_tol;
                     if (wr) begin
                        next_cur.speed_tol = val;
                     end
                  end
               end
               default: begin
                  rval = dswt_pkg::ERR_UNDEF_PARAM;
               end
            endcase
         end
         next_cur.resp_valid = 1'b1;
         next_cur.resp_w1    = {rcode, 1'b0, num};
         next_cur.resp_w2    = idx;
         next_cur.resp_w3    = rval;
      end

      // telegram: send words 0 .. length-1 of the chosen port
      case (cur.tx)
         dswt_pkg::TX_IDLE: begin
            if (tx_start &&
                dswt_len(tx_port, cur.pd_len_a, cur.pd_len_b) != 5'h00) begin
               next_cur.tx      = dswt_pkg::TX_SEND;
               next_cur.tx_port = tx_port;
               next_cur.tx_idx  = 4'h0;
               next_cur.pd_word = link.sel_word;
            end
         end
         dswt_pkg::TX_SEND: begin
            if (pd_ready) begin
               if (5'(cur.tx_idx) + 5'h01 >= cur_len) begin
                  next_cur.tx = dswt_pkg::TX_IDLE;
               end else begin
                  next_cur.tx_idx  = load_idx;
                  next_cur.pd_word = link.sel_word;
               end
            end
         end
         default: begin
            next_cur.tx = dswt_pkg::TX_IDLE;
         end
      endcase
   end

   // register the whole state; settings take their reset values
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cur          <= '0;
         cur.pd_len_a <= dswt_pkg::RST_PD_LEN;
         cur.pd_len_b <= dswt_pkg::RST_PD_LEN;
         cur.sel_a    <= {{15{dswt_pkg::RST_SEL_OTHER}},
                          dswt_pkg::RST_SEL_FIRST};
         cur.sel_b    <= {{15{dswt_pkg::RST_SEL_OTHER}},
                          dswt_pkg::RST_SEL_FIRST};
         cur.speed_tol <= dswt_pkg::RST_SPEED_TOL;
         cur.tx       <= dswt_pkg::TX_IDLE;
      end else begin
         cur <= next_cur;
      end
   end

   // outputs straight from the state
   assign tx_busy        = (cur.tx == dswt_pkg::TX_SEND);
   assign pd_valid       = (cur.tx == dswt_pkg::TX_SEND);
   assign pd_word        = cur.pd_word;
   assign pd_index       = cur.tx_idx;
   assign pd_last        = pd_valid && (5'(cur.tx_idx) + 5'h01 >= cur_len);
   assign pkw_resp_valid = cur.resp_valid;
   assign pkw_resp_w1    = cur.resp_w1;
   assign pkw_resp_w2    = cur.resp_w2;
   assign pkw_resp_w3    = cur.resp_w3;

endmodule : dswt_top
`default_nettype wire

// File: dswt_chk_assertions.sv
// dswt_chk: port timing checks for dswt_top
// assumes one clock and bind onto dswt_top
`timescale 1ns/1ps
`default_nettype none
module dswt_chk (
   input wire logic        clock, arst_n, pkw_req_valid, pkw_resp_valid,
   input wire logic        pd_valid, pd_ready, pd_last, // telegram flow
   input wire logic [15:0] pkw_req_w1, pkw_req_w2, pkw_resp_w1, pkw_resp_w3,
   input wire logic [15:0] fault_number, warning_number, pd_word,
   input wire logic [3:0]  pd_index // word position
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // a word taken by the host, and an indexed read of one parameter
   sequence s_take; pd_valid && pd_ready; endsequence
   sequence s_read(logic [10:0] n);
      pkw_req_valid && pkw_req_w1 == {4'h6, 1'b0, n} && pkw_req_w2 == 16'h0;
   endsequence
   a_resp_follows: assert property (pkw_req_valid |=> pkw_resp_valid)
      else $error("request left unanswered");
   a_resp_caused: assert property (pkw_resp_valid |-> $past(pkw_req_valid))
      else $error("response without request");
   a_fault_read: assert property (s_read(11'h390) |=> pkw_resp_w1 == 16'h4390
      && pkw_resp_w3 == $past(fault_number)) else $error("fault read wrong");
   a_warn_read: assert property (s_read(11'h391) |=> pkw_resp_w1 == 16'h4391
      && pkw_resp_w3 == $past(warning_number)) else $error("warn read wrong");
   a_word_holds: assert property (pd_valid && !pd_ready |=> pd_valid
      && $stable(pd_word) && $stable(pd_index)) else $error("word moved");
   a_first_index: assert property ($rose(pd_valid) |-> pd_index == 4'h0)
      else $error("telegram not at word 0");
   a_index_steps: assert property (s_take ##0 !pd_last |=> pd_valid
      && pd_index == $past(pd_index) + 4'h1) else $error("index skipped");
   a_last_ends: assert property (s_take ##0 pd_last |=> !pd_valid)
      else $error("words past last");
endmodule : dswt_chk
bind dswt_top dswt_chk dswt_chk_inst (.clock, .arst_n, .pkw_req_valid,
   .pkw_resp_valid, .pd_valid, .pd_ready, .pd_last, .pkw_req_w1, .pkw_req_w2,
   .pkw_resp_w1, .pkw_resp_w3, .fault_number, .warning_number, .pd_word,
   .pd_index);
`default_nettype wire

// File: dswt_host.sv
// dswt_host: host-side sink and connector value source
// assumes pd_word stands until taken
`timescale 1ns/1ps
`default_nettype none
module dswt_host (
   input  wire logic        clock, arst_n, pd_valid, // clock, reset, word up
   input  wire logic [9:0]  conn_query, // connector asked for
   input  wire logic [15:0] pd_word,    // word offered
   input  wire logic [3:0]  pd_index,   // its position
   output logic      [17:0] conn_raw,   // value of that connector
   output logic             pd_ready,   // sink takes word
   output logic      [15:0] got [16],   // words kept by position
   output logic      [4:0]  count       // words taken so far
);
   // each connector reads back its own number
   assign conn_raw = {8'h00, conn_query};
   // sink stalls every other cycle so words must stand
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pd_ready <= 1'b0;
         count    <= 5'h00;
      end else begin
         pd_ready <= ~pd_ready;
         if (pd_valid && pd_ready) begin
            got[pd_index] <= pd_word;
            count         <= count + 5'h01;
         end
      end
   end
endmodule : dswt_host
`default_nettype wire

// File: testbench.sv
// testbench: drives status flags, parameter requests and telegrams
// assumes dswt_top with checker bound in
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clock, arst_n, tx_start, pd_valid, pd_ready, pkw_req_valid;
   logic pkw_resp_valid, tx_busy, pd_last;
   logic [9:0] drv, conn_query;
   logic [17:0] conn_raw;
   logic [15:0] speed_fb, w1, w2, w3, r1, r2, r3, pd_word, got [16];
   logic [3:0] pd_index;
   logic [4:0] count, c0;
   int bad_count = 0, checked = 0;
   typedef struct {logic [9:0] i; logic [15:0] d, e;} dswt_row_t;
   dswt_row_t rows [5] = '{'{10'h20C, 16'h0000, 16'h0131},
      '{10'h38C, 16'h0200, 16'h0132}, '{10'h074, 16'h0201, 16'h00EC},
      '{10'h009, 16'hFE00, 16'h0550}, '{10'h102, 16'h0000, 16'h0140}};
   dswt_top dswt_top_inst (.clock, .arst_n, .base_ready(drv[9]),
      .start_request(drv[8]), .drive_disabled(drv[7]), .running(drv[6]),
      .fault_active(drv[5]), .warning_active(drv[4]), .coast_stop_n(drv[3]),
      .quick_stop_n(drv[2]), .other_block(drv[1]), .speed_above(drv[0]),
      .speed_ref(16'h1000), .speed_fb, .fault_number(speed_fb),
      .warning_number(~speed_fb), .status_word_two(16'h0ABC),
      .status_word_three(16'h0DEF), .conn_query, .conn_raw, .pkw_req_valid,
      .pkw_req_w1(w1), .pkw_req_w2(w2), .pkw_req_w3(w3), .pkw_resp_valid,
      .pkw_resp_w1(r1), .pkw_resp_w2(r2), .pkw_resp_w3(r3), .tx_start,
      .tx_port(1'b0), .tx_busy, .pd_valid, .pd_ready, .pd_word, .pd_index,
      .pd_last);
   dswt_host dswt_host_inst (.clock, .arst_n, .pd_valid, .conn_query,
      .pd_word, .pd_index, .conn_raw, .pd_ready, .got, .count);
   // compare one word
   task automatic cmp(input logic [15:0] g, e);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %0t: got %h want %h", $time, g, e);
      end
   endtask : cmp
   // one parameter request and its answer
   task automatic parameter_channel(input logic [15:0] a, b, c, ea, ec);
      @(posedge clock) #1 {pkw_req_valid, w1, w2, w3} = {1'b1, a, b, c};
      @(posedge clock) #1 pkw_req_valid = 1'b0;
      cmp({15'h0000, pkw_resp_valid}, 16'h0001);
      cmp(r1, ea);
      cmp(r2, b);
      cmp(r3, ec);
   endtask : parameter_channel
   // one telegram, waited out under a bound
   task automatic send;
      c0 = count;
      @(posedge clock) #1 tx_start = 1'b1;
      @(posedge clock) #1 tx_start = 1'b0;
      for (int k = 0; k < 60 && tx_busy; k++) @(posedge clock) #1;
   endtask : send
   task automatic tally_and_finish;
      $display("checked %0d bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish
   // clock and watchdog
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      #50000 bad_count++;
      tally_and_finish();
   end
   // a length, status rows, then reads, selections and lengths
   initial begin
      {arst_n, tx_start, pkw_req_valid, drv, speed_fb, w1, w2, w3} = '0;
      repeat (6) @(posedge clock);
      #1 arst_n = 1'b1;
      parameter_channel(16'h730D, 16'h0, 16'h0011, 16'h730D, 16'h0002);
      parameter_channel(16'h730D, 16'h0, 16'h0001, 16'h430D, 16'h0001);
      foreach (rows[n]) begin
         {drv, speed_fb} = {rows[n].i, 16'h1000 + rows[n].d};
         send();
         cmp(got[0], rows[n].e);
         cmp({11'h0, count - c0}, 16'h0001);
      end
      parameter_channel(16'h6390, 16'h0, 16'h0, 16'h4390, speed_fb);
      parameter_channel(16'h6391, 16'h0, 16'h0, 16'h4391, ~speed_fb);
      parameter_channel(16'h7310, 16'h1, 16'h0146, 16'h4310, 16'h0146);
      parameter_channel(16'h7310, 16'h2, 16'h01F4, 16'h4310, 16'h01F4);
      parameter_channel(16'h730D, 16'h0, 16'h0003, 16'h430D, 16'h0003);
      send();
      cmp(got[1], 16'h0ABC);
      cmp(got[2], 16'h01F4);
      cmp({11'h0, count - c0}, 16'h0003);
      parameter_channel(16'h7310, 16'h0, 16'h0, 16'h4310, 16'h0);
      send();
      cmp(got[0], 16'h0000);
      // mid-run reset
      arst_n = 1'b0;
      @(posedge clock) #1 arst_n = 1'b1;
      parameter_channel(16'h6398, 16'h0, 16'h0, 16'h4398, 16'h0200);
      send();
      cmp({11'h0, count - c0}, 16'h0000);
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
